// *** inc/i2c_regs_defines.vh ***
// Notes on behaviour
// - Receive data read returns next FIFO byte in bits 7:0, bit 0 first received.
// - Serial clock is held low while the receive FIFO is full.
// - Slave addressed for write-to-slave raises the write-to-slave request flag.
// - In DMA mode receive single requests follow the receive FIFO entry count.
// - Transmit nearly-empty flag set while transmit count is at or below threshold.
// - Receive nearly-full flag set while receive count is at or above threshold.
// - Transmit burst size field matters only while burst request mode is set.
// - Burst size larger than transaction length gives single requests only.
// - Request mode bit picks one-byte requests or programmed-size burst requests.
// - Burst mode may finish a transfer with single requests for the remainder.
// - Master serial clock rate comes from the 16-bit counter, reset value 0x8.
`ifndef I2C_REGS_DEFINES_VH
`define I2C_REGS_DEFINES_VH

`define OFS_RX_FIFO_DATA      8'h18
`define OFS_TX_FIFO_THRESHOLD 8'h1C
`define OFS_RX_FIFO_THRESHOLD 8'h20
`define OFS_DMA_REQUEST_CFG   8'h24
`define OFS_BAUD_RATE_DIVIDER 8'h28
`define OFS_DMA_ENABLE        8'h34
`define OFS_FIFO_STATUS       8'h38

`define DMA_BURST_LEN_LSB     8
`define DMA_BURST_LEN_MSB     10
`define DMA_BURST_MODE_BIT    11

`define RST_LEVEL_LIMIT       10'h000
`define RST_SCL_RATE_COUNT    16'h0008
`define RST_BURST_LEN         3'h0

`define RX_FIFO_DEPTH         4'h8
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// *** src/i2c_fifo_dma_baud_regs.v ***
`timescale 1ns/1ps
`include "i2c_regs_defines.vh"
module i2c_fifo_dma_baud_regs (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Bus engine side
  input  wire [7:0]  rx_byte,
  input  wire        rx_byte_valid,
  output wire        rx_byte_ready,
  input  wire [9:0]  tx_fifo_level,
  input  wire        wts_addressed,
  input  wire [10:0] tx_dma_remaining,
  // Flags and controls
  output wire        scl_hold_low,
  output wire        write_to_slave_req_flag,
  output wire        rx_nearly_full_flag,
  output wire        tx_nearly_empty_flag,
  output wire [15:0] scl_rate_count,
  // DMA requests
  output wire        rx_dma_single_req,
  output wire        tx_dma_single_req,
  output wire        tx_dma_burst_req,
  output wire [2:0]  tx_dma_burst_len
);

  reg        awready_r;
  reg        wready_r;
  reg        bvalid_r;
  reg [1:0]  bresp_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  reg        arready_r;
  reg        rvalid_r;
  reg [1:0]  rresp_r;
  reg [31:0] rdata_r;

  reg [9:0]  tx_level_limit_r;
  reg [9:0]  rx_level_limit_r;
  reg [2:0]  tx_dma_burst_len_r;
  reg        tx_burst_mode_r;
  reg [15:0] scl_rate_count_r;
  reg [1:0]  dma_enable_r;

  reg        scl_hold_low_r;
  reg        wts_flag_r;
  reg        rx_nf_flag_r;
  reg        tx_ne_flag_r;
  reg        rx_dma_single_r;
  reg        tx_dma_single_r;
  reg        tx_dma_burst_r;
  reg [2:0]  burst_len_out_r;

  // Two-entry buffer ahead of the receive FIFO
  reg [7:0]  buf0_r;
  reg [7:0]  buf1_r;
  reg [1:0]  buf_cnt_r;
  reg [1:0]  buf_cnt_nxt;
  reg        buf_ready_r;

  reg [7:0]  rx_mem_r [0:7];
  reg [2:0]  rx_wr_ptr_r;
  reg [2:0]  rx_rd_ptr_r;
  reg [3:0]  rx_cnt_r;
  reg [3:0]  rx_cnt_nxt;

  reg [31:0] rd_val;
  reg [1:0]  rd_resp;
  reg        rd_pop;

  wire       buf_acc  = rx_byte_valid & buf_ready_r;
  wire       buf_drain = (buf_cnt_r != 2'h0) & (rx_cnt_r != `RX_FIFO_DEPTH);
  wire       ar_take  = s_axi_arvalid & arready_r;
  wire       do_write = ~awready_r & ~wready_r & ~bvalid_r;
  wire [7:0] wr_sel   = 8'h01 << rx_wr_ptr_r;
  wire [31:0] wmask   = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wbits   = wdata_r & wmask;
  wire [10:0] burst_bytes = 11'h001 << tx_dma_burst_len_r;
  wire       tx_want  = dma_enable_r[1] & tx_ne_flag_r & (tx_dma_remaining != 11'h000);
  // Burst only when the burst exactly covers what is left; else singles
  wire       burst_ok = tx_burst_mode_r & (burst_bytes == tx_dma_remaining);

  // Receive FIFO storage, one flop group per entry
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_rx_entry
      always @(posedge aclk) begin
        if (!aresetn) begin
          rx_mem_r[gi] <= 8'h00;
        end else if (buf_drain && wr_sel[gi]) begin
          rx_mem_r[gi] <= buf0_r;
        end
      end
    end
  endgenerate

  always @* begin
    buf_cnt_nxt = buf_cnt_r + {1'b0, buf_acc} - {1'b0, buf_drain};
    rx_cnt_nxt  = rx_cnt_r + {3'h0, buf_drain} - {3'h0, rd_pop};
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      buf0_r      <= 8'h00;
      buf1_r      <= 8'h00;
      buf_cnt_r   <= 2'h0;
      buf_ready_r <= 1'b0;
    end else begin
      if (buf_drain) begin
        buf0_r <= buf1_r;
      end
      if (buf_acc) begin
        if ((buf_cnt_r - {1'b0, buf_drain}) == 2'h0) begin
          buf0_r <= rx_byte;
        end else begin
          buf1_r <= rx_byte;
        end
      end
      buf_cnt_r   <= buf_cnt_nxt;
      buf_ready_r <= (buf_cnt_nxt != 2'h2);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_wr_ptr_r <= 3'h0;
      rx_rd_ptr_r <= 3'h0;
      rx_cnt_r    <= 4'h0;
    end else begin
      if (buf_drain) begin
        rx_wr_ptr_r <= rx_wr_ptr_r + 3'h1;
      end
      if (rd_pop) begin
        rx_rd_ptr_r <= rx_rd_ptr_r + 3'h1;
      end
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  // Read decode; an empty FIFO reads zero and pops nothing
  always @* begin
    rd_val  = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    rd_pop  = 1'b0;
    case ({s_axi_araddr[7:2], 2'h0})
      `OFS_RX_FIFO_DATA: begin
        if (rx_cnt_r != 4'h0) begin
          rd_val = {24'h00_0000, rx_mem_r[rx_rd_ptr_r]};
          rd_pop = ar_take;
        end
      end
      `OFS_TX_FIFO_THRESHOLD: rd_val = {22'h0, tx_level_limit_r};
      `OFS_RX_FIFO_THRESHOLD: rd_val = {22'h0, rx_level_limit_r};
      `OFS_DMA_REQUEST_CFG:   rd_val = {20'h0_0000, tx_burst_mode_r, tx_dma_burst_len_r, 8'h00};
      `OFS_BAUD_RATE_DIVIDER: rd_val = {16'h0000, scl_rate_count_r};
      `OFS_DMA_ENABLE:        rd_val = {30'h0, dma_enable_r};
      `OFS_FIFO_STATUS: begin
        rd_val = {20'h0_0000, rx_cnt_r, 4'h0, scl_hold_low_r, rx_nf_flag_r,
                  tx_ne_flag_r, wts_flag_r};
      end
      default: rd_resp = `RESP_SLVERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= rd_resp;
      rdata_r   <= rd_val;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // Address and data are latched independently; write happens once both are held
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awready_r <= 1'b0;
        awaddr_r  <= s_axi_awaddr;
      end else if (bvalid_r && s_axi_bready) begin
        awready_r <= 1'b1;
      end
      if (s_axi_wvalid && wready_r) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (bvalid_r && s_axi_bready) begin
        wready_r <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r           <= 1'b0;
      bresp_r            <= `RESP_OKAY;
      tx_level_limit_r   <= `RST_LEVEL_LIMIT;
      rx_level_limit_r   <= `RST_LEVEL_LIMIT;
      tx_dma_burst_len_r <= `RST_BURST_LEN;
      tx_burst_mode_r    <= 1'b0;
      scl_rate_count_r   <= `RST_SCL_RATE_COUNT;
      dma_enable_r       <= 2'h0;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= `RESP_OKAY;
      case ({awaddr_r[7:2], 2'h0})
        `OFS_RX_FIFO_DATA: begin
        end
        `OFS_TX_FIFO_THRESHOLD: begin
          tx_level_limit_r <= (tx_level_limit_r & ~wmask[9:0]) | wbits[9:0];
        end
        `OFS_RX_FIFO_THRESHOLD: begin
          rx_level_limit_r <= (rx_level_limit_r & ~wmask[9:0]) | wbits[9:0];
        end
        `OFS_DMA_REQUEST_CFG: begin
          if (wstrb_r[1]) begin
            tx_dma_burst_len_r <= wdata_r[`DMA_BURST_LEN_MSB:`DMA_BURST_LEN_LSB];
            tx_burst_mode_r    <= wdata_r[`DMA_BURST_MODE_BIT];
          end
        end
        `OFS_BAUD_RATE_DIVIDER: begin
          scl_rate_count_r <= (scl_rate_count_r & ~wmask[15:0]) | wbits[15:0];
        end
        `OFS_DMA_ENABLE: begin
          if (wstrb_r[0]) begin
            dma_enable_r <= wdata_r[1:0];
          end
        end
        `OFS_FIFO_STATUS: begin
        end
        default: bresp_r <= `RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Flags and DMA requests, registered so every output is a flop
  always @(posedge aclk) begin
    if (!aresetn) begin
      scl_hold_low_r  <= 1'b0;
      wts_flag_r      <= 1'b0;
      rx_nf_flag_r    <= 1'b0;
      tx_ne_flag_r    <= 1'b0;
      rx_dma_single_r <= 1'b0;
      tx_dma_single_r <= 1'b0;
      tx_dma_burst_r  <= 1'b0;
      burst_len_out_r <= 3'h0;
    end else begin
      // Hold SCL while full: the buffer cannot absorb a whole byte stream
      scl_hold_low_r  <= (rx_cnt_nxt == `RX_FIFO_DEPTH);
      wts_flag_r      <= wts_addressed;
      rx_nf_flag_r    <= ({6'h00, rx_cnt_nxt} >= rx_level_limit_r);
      tx_ne_flag_r    <= (tx_fifo_level <= tx_level_limit_r);
      rx_dma_single_r <= dma_enable_r[0] & (rx_cnt_nxt != 4'h0);
      tx_dma_burst_r  <= tx_want & burst_ok;
      tx_dma_single_r <= tx_want & ~burst_ok;
      burst_len_out_r <= tx_burst_mode_r ? tx_dma_burst_len_r : 3'h0;
    end
  end

  assign s_axi_awready           = awready_r;
  assign s_axi_wready            = wready_r;
  assign s_axi_bvalid            = bvalid_r;
  assign s_axi_bresp             = bresp_r;
  assign s_axi_arready           = arready_r;
  assign s_axi_rvalid            = rvalid_r;
  assign s_axi_rresp             = rresp_r;
  assign s_axi_rdata             = rdata_r;
  assign rx_byte_ready           = buf_ready_r;
  assign scl_hold_low            = scl_hold_low_r;
  assign write_to_slave_req_flag = wts_flag_r;
  assign rx_nearly_full_flag     = rx_nf_flag_r;
  assign tx_nearly_empty_flag    = tx_ne_flag_r;
  assign scl_rate_count          = scl_rate_count_r;
  assign rx_dma_single_req       = rx_dma_single_r;
  assign tx_dma_single_req       = tx_dma_single_r;
  assign tx_dma_burst_req        = tx_dma_burst_r;
  assign tx_dma_burst_len        = burst_len_out_r;

endmodule // i2c_fifo_dma_baud_regs

// *** verification/i2c_fifo_dma_baud_regs_tb.sv ***
`timescale 1ns/1ps
module i2c_fifo_dma_baud_regs_tb;
  logic aclk = 0, aresetn = 0, start = 0, slow = 0, wts_addressed = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rx_byte, base = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, count = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_byte_valid, rx_byte_ready, busy, scl_hold_low;
  logic write_to_slave_req_flag, rx_nearly_full_flag, tx_nearly_empty_flag;
  logic rx_dma_single_req, tx_dma_single_req, tx_dma_burst_req;
  logic [9:0] tx_fifo_level = 0;
  logic [10:0] tx_dma_remaining = 0;
  logic [15:0] scl_rate_count;
  logic [2:0] tx_dma_burst_len;
  int n_fail = 0, compares = 0, lim;
  always #25 aclk = ~aclk;
  i2c_fifo_dma_baud_regs DUT (.*);
  rx_engine_model partner (.*);
  function automatic logic [7:0] rx_exp(input logic [7:0] b, input int k);
    return b + 8'(k) * 8'h3B;
  endfunction
  function automatic logic [4:0] dma_exp(input logic m, input logic [2:0] l, input logic [10:0] r);
    if (r == 0) return {2'b00, m ? l : 3'h0};
    if (m && r == (11'h001 << l)) return {2'b01, l};
    return {2'b10, m ? l : 3'h0};
  endfunction
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic stall;
    chk("wait bound", 0, 1);
    report_and_stop;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 0;
    if (!s_axi_bvalid) stall;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 0;
    if (!s_axi_rvalid) stall;
    chk("rdata", e & m, s_axi_rdata & m);
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic send(input logic [3:0] c);
    int n;
    base <= 8'($urandom);
    count <= c;
    slow <= 1'($urandom);
    start <= 1;
    @(posedge aclk);
    start <= 0;
    @(posedge aclk);
    for (n = 0; busy && n < 200; n++) @(posedge aclk);
    if (busy) stall;
    repeat (4) @(posedge aclk);
  endtask
  initial begin
    void'($urandom(72));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(8'h1C, 0, 32'h3FF, 0);
    rd(8'h20, 0, 32'h3FF, 0);
    rd(8'h24, 0, 32'hF00, 0);
    rd(8'h28, 8, 32'hFFFF, 0);
    rd(8'h0C, 0, 32'hFFFFFFFF, 2);
    wr(8'h0C, 0, 2);
    wr(8'h18, 32'hFF);
    rd(8'h18, 0, 32'hFFFFFFFF, 0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(8'h1C + 8'(4 * i), d);
      rd(8'h1C + 8'(4 * i), d, i == 2 ? 32'hF00 : i == 3 ? 32'hFFFF : 32'h3FF, 0);
    end
    chk("rate", d[15:0], scl_rate_count);
    $display("test registers done");
    lim = $urandom_range(1, 1022);
    wr(8'h1C, lim);
    for (int k = -1; k < 2; k++) begin
      tx_fifo_level <= 10'(lim + k);
      repeat (3) @(posedge aclk);
      chk("txne", k <= 0, tx_nearly_empty_flag);
    end
    $display("test tx level done");
    wr(8'h20, 5);
    send(10);
    chk("stall", 0, rx_byte_ready);
    rd(8'h38, 32'h80C, 32'hFFFFFFFF, 0);
    for (int k = 0; k < 10; k++) begin
      rd(8'h18, rx_exp(base, k), 32'hFFFFFFFF, 0);
      repeat (4) @(posedge aclk);
      chk("rxnf", 9 - k >= 5, rx_nearly_full_flag);
      chk("hold", 9 - k >= 8, scl_hold_low);
    end
    $display("test rx fifo done");
    wr(8'h34, 3);
    rd(8'h34, 3, 32'h3, 0);
    wr(8'h1C, 32'h3FF);
    tx_fifo_level <= 0;
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[11] = i[0] | i[1];
      tx_dma_remaining <= i[0] ? 11'h001 << d[10:8] : 11'(d[31:20] % 12'd5);
      wr(8'h24, d);
      repeat (3) @(posedge aclk);
      chk("txdma", dma_exp(d[11], d[10:8], tx_dma_remaining),
        {tx_dma_single_req, tx_dma_burst_req, tx_dma_burst_len});
    end
    chk("rxdma", 0, rx_dma_single_req);
    send(1);
    chk("rxdma", 1, rx_dma_single_req);
    rd(8'h18, rx_exp(base, 0), 32'hFFFFFFFF, 0);
    repeat (3) @(posedge aclk);
    chk("rxdma", 0, rx_dma_single_req);
    wts_addressed <= 1;
    @(posedge aclk);
    wts_addressed <= 0;
    @(negedge aclk);
    chk("wts", 1, write_to_slave_req_flag);
    @(negedge aclk);
    chk("wts", 0, write_to_slave_req_flag);
    $display("test dma and events done");
    @(posedge aclk);
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(8'h28, 8, 32'hFFFF, 0);
    $display("test second reset done");
    report_and_stop;
  end
endmodule // i2c_fifo_dma_baud_regs_tb

// *** verification/i2c_regs_asserts.sv ***
`timescale 1ns/1ps
module i2c_regs_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Engine side and flags
  input wire logic        rx_byte_ready,
  input wire logic        wts_addressed,
  input wire logic [10:0] tx_dma_remaining,
  input wire logic        scl_hold_low,
  input wire logic        write_to_slave_req_flag,
  input wire logic [15:0] scl_rate_count,
  input wire logic        tx_dma_single_req,
  input wire logic        tx_dma_burst_req,
  input wire logic [2:0]  tx_dma_burst_len
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_wts_echo: assert property (wts_addressed |=> write_to_slave_req_flag)
    else $error("write-to-slave flag missed");
  a_rate_reset: assert property ($rose(aresetn) |-> scl_rate_count == 16'h0008)
    else $error("rate count not at reset value");
  a_req_onehot: assert property (!(tx_dma_single_req && tx_dma_burst_req))
    else $error("single and burst request together");
  a_burst_exact: assert property (tx_dma_burst_req |->
    $past(tx_dma_remaining) == (11'h001 << tx_dma_burst_len)) else $error("burst not whole");
  a_req_remain: assert property (tx_dma_single_req |-> $past(tx_dma_remaining) != 11'h000)
    else $error("single request with nothing left");
  a_stall_hold: assert property ($fell(rx_byte_ready) |-> ##[0:2] scl_hold_low)
    else $error("stall without clock hold");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
endmodule // i2c_regs_asserts

bind i2c_fifo_dma_baud_regs i2c_regs_asserts chk_i (.*);

// *** verification/rx_engine_model.sv ***
`timescale 1ns/1ps
module rx_engine_model (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Bench control
  input wire logic [7:0] base,
  input wire logic [3:0] count,
  input wire logic       start,
  input wire logic       slow,
  output logic           busy,
  // Byte stream
  output logic [7:0]     rx_byte = 8'hA5,
  output logic           rx_byte_valid = 1'b0,
  input wire logic       rx_byte_ready
);
  logic [3:0] left_r = 4'h0;
  logic [7:0] next_r = 8'h00;
  logic       gap_r = 1'b0;
  assign busy = left_r != 4'h0;
  always @(posedge aclk) begin
    if (!aresetn) begin
      left_r <= 4'h0;
      rx_byte_valid <= 1'b0;
    end else if (start) begin
      left_r <= count;
      next_r <= base;
    end else if (rx_byte_valid) begin
      if (rx_byte_ready) begin
        // Released data turns over so a stale byte is never mistaken
        rx_byte_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        left_r <= left_r - 4'h1;
        next_r <= next_r + 8'h3B;
        gap_r <= slow;
      end
    end else if (gap_r) begin
      gap_r <= 1'b0;
    end else if (busy) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= next_r;
    end
  end
endmodule // rx_engine_model
